// >>> hdl/tbsp_regs.svh
// Purpose: constants of the backplane signaling port
// Assumes: one 10 MHz core clock
// Notes: defines only
`ifndef TBSP_REGS_SVH
`define TBSP_REGS_SVH
`define TBSP_CLK_PERIOD_NS 100
`define TBSP_BIT_RATE_KBPS 2048
`define TBSP_RESET_MIN_NS 1000
`define TBSP_RESET_MIN_CYC \
	((`TBSP_RESET_MIN_NS + `TBSP_CLK_PERIOD_NS - 1) / `TBSP_CLK_PERIOD_NS)
`define TBSP_SLOT_BITS 8
`define TBSP_SLOTS 32
`define TBSP_SIG_CHANNELS 30
`define TBSP_E1_CHANNELS 30
`define TBSP_T1_CHANNELS 24
`define TBSP_SIG_SLOT 5'h10
`define TBSP_IDLE_BYTE 8'hff
`define TBSP_FIFO_DEPTH 8
`define TBSP_LAST_BIT 3'h7
`define TBSP_LAST_NIB_BIT 2'h3
`endif

// >>> hdl/tbsp_pkg.sv
// Purpose: types of the backplane signaling port
// Assumes: nothing
// Notes: constants live in tbsp_regs.svh
package tbsp_pkg;
	typedef logic [4:0] tbsp_slot_t;
	typedef logic [3:0] tbsp_nib_t;
	typedef logic [7:0] tbsp_byte_t;
	typedef logic [7:0] tbsp_pos_t;
endpackage

// >>> hdl/tbsp_fifo.sv
// Purpose: small flop fifo between line side and backplane
// Assumes: one clock, synchronous active-low reset
// Notes: in_ready is registered so it can feed a top port directly
`timescale 1ns/100ps
module tbsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_reg];

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = CW'(count_reg + 1'b1);
		else if (pop && !push)
			count_next = CW'(count_reg - 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			count_reg <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			in_ready <= (count_next != CW'(DEPTH));
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= bump(wr_reg);
			if (pop)
				rd_reg <= bump(rd_reg);
		end
	end

	// data words need no reset, only the pointers, the count and in_ready do
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
endmodule

// >>> hdl/tbsp_port.sv
// Purpose: backplane data and signaling streams of a T1/E1 framer
// Assumes: bit_strobe and frame_pulse synchronous to clk
// Notes: one bit per strobe, 256 bits per frame
`timescale 1ns/100ps
`include "tbsp_regs.svh"
module tbsp_port #(
	parameter int FIFO_DEPTH = `TBSP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// configuration
	input wire logic nibble_position_select,
	input wire logic signaling_source_select,
	input wire logic e1_mode,
	// backplane timing
	input wire logic bit_strobe,
	input wire logic frame_pulse,
	// backplane streams
	input wire logic backplane_data_in,
	input wire logic signaling_control_in,
	output logic backplane_data_out,
	output logic signaling_status_out,
	output logic signaling_status_oe,
	// received channels from the line
	input wire tbsp_pkg::tbsp_byte_t rx_ch_data,
	input wire logic rx_ch_valid,
	output logic rx_ch_ready,
	// received signaling from the line
	input wire logic rx_sig_wr,
	input wire tbsp_pkg::tbsp_slot_t rx_sig_ch,
	input wire tbsp_pkg::tbsp_nib_t rx_sig_nibble,
	// channels to transmit
	output tbsp_pkg::tbsp_byte_t tx_ch_data,
	output tbsp_pkg::tbsp_slot_t tx_ch_num,
	output logic tx_ch_valid,
	// transmit signaling
	output tbsp_pkg::tbsp_nib_t tx_sig_nibble,
	output tbsp_pkg::tbsp_slot_t tx_sig_ch,
	output logic tx_sig_valid
);
	import tbsp_pkg::*;

	tbsp_pos_t pos_reg;
	tbsp_pos_t pos_now;
	tbsp_slot_t slot;
	logic [2:0] bitn;
	logic sig_slot;
	logic data_slot;
	logic valid_half;
	tbsp_byte_t dbyte_reg;
	tbsp_byte_t cur_byte;
	tbsp_byte_t fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	tbsp_nib_t sig_mem [0:`TBSP_SLOTS-1];
	logic [2:0] cin_sh_reg;
	logic [6:0] din_sh_reg;

	function automatic logic is_sig_slot(input tbsp_slot_t s);
		is_sig_slot = (s != 5'h00) && (s != `TBSP_SIG_SLOT);
	endfunction

	function automatic tbsp_slot_t ch_of_slot(input tbsp_slot_t s);
		ch_of_slot = (s < `TBSP_SIG_SLOT) ? s : 5'(s - 1'b1);
	endfunction

	// frame pulse restarts the count at bit 0 of slot 0
	assign pos_now = frame_pulse ? 8'h00 : 8'(pos_reg + 1'b1);
	assign slot = pos_now[7:3];
	assign bitn = pos_now[2:0];
	assign sig_slot = is_sig_slot(slot);
	// t1 packs its 24 channels into the first slots after slot 0
	assign data_slot = e1_mode ? sig_slot :
		(slot != 5'h00 && slot <= 5'(`TBSP_T1_CHANNELS));
	// msb goes first, so bits 0..3 are the upper nibble
	assign valid_half = (bitn[2] != nibble_position_select);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			pos_reg <= 8'h00;
		else if (bit_strobe)
			pos_reg <= pos_now;
	end

	// receive data: one fifo word per data slot, idle when starved
	assign fifo_pop = bit_strobe && data_slot && bitn == 3'h0;
	assign cur_byte = (bitn != 3'h0) ? dbyte_reg :
		(fifo_valid ? fifo_data : `TBSP_IDLE_BYTE);

	tbsp_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data(rx_ch_data),
		.in_valid(rx_ch_valid),
		.in_ready(rx_ch_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			dbyte_reg <= `TBSP_IDLE_BYTE;
			backplane_data_out <= 1'b1;
		end
		else if (bit_strobe)
		begin
			if (bitn == 3'h0)
				dbyte_reg <= cur_byte;
			backplane_data_out <= data_slot ?
				cur_byte[3'(`TBSP_LAST_BIT - bitn)] : 1'b1;
		end
	end

	// receive signaling table, indexed by slot
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < `TBSP_SLOTS; i++)
				sig_mem[i] <= 4'h0;
		end
		else if (rx_sig_wr && rx_sig_ch != 5'h00 &&
			rx_sig_ch <= 5'(`TBSP_SIG_CHANNELS))
		begin
			if (rx_sig_ch < `TBSP_SIG_SLOT)
				sig_mem[rx_sig_ch] <= rx_sig_nibble;
			else
				sig_mem[5'(rx_sig_ch + 1'b1)] <= rx_sig_nibble;
		end
	end

	// status stream: slots 0 and 16 carry no channel, so stay undriven
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			signaling_status_oe <= 1'b0;
			signaling_status_out <= 1'b0;
		end
		else if (bit_strobe)
		begin
			signaling_status_oe <= sig_slot && valid_half;
			signaling_status_out <= (sig_slot && valid_half) ?
				sig_mem[slot][2'(`TBSP_LAST_NIB_BIT - bitn[1:0])] :
				1'b0;
		end
	end

	// transmit signaling, gated off entirely by the source select
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cin_sh_reg <= 3'h0;
			tx_sig_nibble <= 4'h0;
			tx_sig_ch <= 5'h00;
			tx_sig_valid <= 1'b0;
		end
		else
		begin
			tx_sig_valid <= 1'b0;
			if (bit_strobe && !signaling_source_select && sig_slot &&
				valid_half)
			begin
				cin_sh_reg <= {cin_sh_reg[1:0], signaling_control_in};
				if (bitn[1:0] == `TBSP_LAST_NIB_BIT)
				begin
					tx_sig_nibble <= {cin_sh_reg, signaling_control_in};
					tx_sig_ch <= ch_of_slot(slot);
					tx_sig_valid <= 1'b1;
				end
			end
		end
	end

	// transmit data deserialiser
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			din_sh_reg <= 7'h00;
			tx_ch_data <= 8'h00;
			tx_ch_num <= 5'h00;
			tx_ch_valid <= 1'b0;
		end
		else
		begin
			tx_ch_valid <= 1'b0;
			if (bit_strobe && data_slot)
			begin
				din_sh_reg <= {din_sh_reg[5:0], backplane_data_in};
				if (bitn == `TBSP_LAST_BIT)
				begin
					tx_ch_data <= {din_sh_reg, backplane_data_in};
					tx_ch_num <= e1_mode ? ch_of_slot(slot) : slot;
					tx_ch_valid <= 1'b1;
				end
			end
		end
	end

	a_frame_align_pos: assert property (
		@(posedge clk) disable iff (!reset_n)
		bit_strobe && frame_pulse |=> pos_reg == 8'h00)
		else $error("bit count not restarted by frame pulse");
	a_data_msb_first: assert property (
		@(posedge clk) disable iff (!reset_n)
		fifo_pop && fifo_valid |=> backplane_data_out == $past(fifo_data[7]))
		else $error("data byte not sent msb first");
	a_data_idle_slot: assert property (
		@(posedge clk) disable iff (!reset_n)
		bit_strobe && !data_slot |=> backplane_data_out)
		else $error("non-channel slot not idle on data out");
	a_status_half_drive: assert property (
		@(posedge clk) disable iff (!reset_n)
		bit_strobe && sig_slot |=> signaling_status_oe ==
		($past(bitn[2]) != $past(nibble_position_select)))
		else $error("status nibble driven in wrong half");
	a_status_slot_zero: assert property (
		@(posedge clk) disable iff (!reset_n)
		bit_strobe && slot == 5'h00 |=> !signaling_status_oe)
		else $error("status driven in slot zero");
	a_ctrl_ignored: assert property (
		@(posedge clk) disable iff (!reset_n)
		signaling_source_select && $past(signaling_source_select)
		|-> !tx_sig_valid)
		else $error("control stream used while disabled");
	a_ctrl_half_sel: assert property (
		@(posedge clk) disable iff (!reset_n)
		tx_sig_valid |-> $past(bitn) ==
		(nibble_position_select ? 3'h3 : 3'h7))
		else $error("control nibble taken from wrong half");
	a_ctrl_channel_range: assert property (
		@(posedge clk) disable iff (!reset_n)
		tx_sig_valid |-> tx_sig_ch >= 5'h01 && tx_sig_ch <= 5'h1e)
		else $error("transmit signaling channel out of range");
	a_data_in_byte: assert property (
		@(posedge clk) disable iff (!reset_n)
		tx_ch_valid |-> $past(bit_strobe) && $past(bitn) == 3'h7 &&
		tx_ch_data[0] == $past(backplane_data_in))
		else $error("transmit byte not closed at bit 7");
endmodule

// >>> dv/tbsp_switch_model.sv
// Purpose: backplane switch model feeding and sampling the port streams
// Assumes: one bit strobe every five clocks
// Notes: bench loads din_b/ctl_b and reads the captured bytes
`timescale 1ns/100ps
module tbsp_switch_model (
	// clock and control
	input wire logic clk,
	input wire logic run,
	// timing and streams towards the port
	output logic bit_strobe = 1'b0,
	output logic frame_pulse = 1'b0,
	output logic backplane_data_in = 1'b1,
	output logic signaling_control_in = 1'b1,
	// streams from the port
	input wire logic backplane_data_out,
	input wire logic signaling_status_out,
	input wire logic signaling_status_oe
);
	logic [7:0] din_b [32];
	logic [7:0] ctl_b [32];
	logic [7:0] dout_b [32];
	logic [7:0] stat_b [32];
	logic [7:0] oe_b [32];
	logic [7:0] pos = 8'hff;
	int cnt = 0;
	int frames = 0;
	// a frame restarts at slot 0 whenever run rises
	always @(negedge clk)
	begin
		// outputs of the strobed bit are settled half a clock later
		if (bit_strobe)
		begin
			dout_b[pos[7:3]][~pos[2:0]] = backplane_data_out;
			oe_b[pos[7:3]][~pos[2:0]] = signaling_status_oe;
			// undriven pin reads as 1 (inverted held-low output), not the last value
			stat_b[pos[7:3]][~pos[2:0]] =
				signaling_status_out ^ ~signaling_status_oe;
			if (pos == 8'hff)
				frames++;
		end
		bit_strobe = 1'b0;
		if (!run)
		begin
			pos = 8'hff;
			cnt = 0;
		end
		else if (++cnt == 5)
		begin
			cnt = 0;
			pos = pos + 8'h1;
			bit_strobe = 1'b1;
			frame_pulse = pos == 8'h0;
			// msb of each slot goes first
			backplane_data_in = din_b[pos[7:3]][~pos[2:0]];
			signaling_control_in = ctl_b[pos[7:3]][~pos[2:0]];
		end
	end
endmodule

// >>> dv/tbsp_port_tb_top.sv
// Purpose: self-checking bench of the backplane signaling port
// Assumes: switch model strobes one bit every five clocks
// Notes: expectations come from q, sig and the model's din_b/ctl_b, never from the port
`timescale 1ns/100ps
`include "tbsp_regs.svh"
module tbsp_port_tb_top;
	import tbsp_pkg::*;
	logic clk = 0, reset_n = 0, run = 0, rx_ch_valid = 0, rx_sig_wr = 0;
	logic nibble_position_select = 0, signaling_source_select = 0;
	logic e1_mode = 0;
	tbsp_byte_t rx_ch_data = 8'h00;
	tbsp_slot_t rx_sig_ch = 5'h00;
	tbsp_nib_t rx_sig_nibble = 4'h0;
	logic bit_strobe, frame_pulse, backplane_data_in, signaling_control_in;
	logic backplane_data_out, signaling_status_out, signaling_status_oe;
	logic rx_ch_ready, tx_ch_valid, tx_sig_valid;
	tbsp_byte_t tx_ch_data;
	tbsp_slot_t tx_ch_num, tx_sig_ch;
	tbsp_nib_t tx_sig_nibble;
	tbsp_byte_t q[$];
	logic [12:0] chq[$];
	logic [8:0] sgq[$];
	tbsp_nib_t sig [32];
	int num_errors = 0, tests_run = 0;

	tbsp_port DUT (.clk, .reset_n, .nibble_position_select,
		.signaling_source_select, .e1_mode, .bit_strobe, .frame_pulse,
		.backplane_data_in, .signaling_control_in, .backplane_data_out,
		.signaling_status_out, .signaling_status_oe, .rx_ch_data,
		.rx_ch_valid, .rx_ch_ready, .rx_sig_wr, .rx_sig_ch,
		.rx_sig_nibble, .tx_ch_data, .tx_ch_num, .tx_ch_valid,
		.tx_sig_nibble, .tx_sig_ch, .tx_sig_valid);
	tbsp_switch_model M (.clk, .run, .bit_strobe, .frame_pulse,
		.backplane_data_in, .signaling_control_in, .backplane_data_out,
		.signaling_status_out, .signaling_status_oe);

	initial
		forever #50 clk = ~clk;

	always @(posedge clk)
	begin
		if (tx_ch_valid === 1'b1)
			chq.push_back({tx_ch_num, tx_ch_data});
		if (tx_sig_valid === 1'b1)
			sgq.push_back({tx_sig_ch, tx_sig_nibble});
	end

	task check(input string nm, input logic [15:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task do_reset;
		int i;
		begin
			@(negedge clk);
			reset_n = 0;
			repeat (`TBSP_RESET_MIN_CYC) @(negedge clk);
			reset_n = 1;
			for (i = 0; i < 32; i++)
				sig[i] = 4'h0;
			q.delete();
		end
	endtask

	task sig_write(input tbsp_slot_t ch, input tbsp_nib_t n);
		@(negedge clk);
		rx_sig_wr = 1;
		rx_sig_ch = ch;
		rx_sig_nibble = n;
		sig[ch] = n;
		@(negedge clk);
		rx_sig_wr = 0;
	endtask

	// offers n bytes; anything past the fifo depth must be refused
	task fill(input int n);
		int k;
		bit a;
		begin
			k = 0;
			rx_ch_data = 8'($urandom);
			rx_ch_valid = n > 0;
			repeat (12)
			begin
				@(posedge clk);
				a = rx_ch_valid && rx_ch_ready === 1'b1;
				if (a)
				begin
					q.push_back(rx_ch_data);
					k++;
				end
				@(negedge clk);
				if (a)
					rx_ch_data = 8'($urandom);
				rx_ch_valid = k < n;
			end
			rx_ch_valid = 0;
			check("fifo_fill", k, n > `TBSP_FIFO_DEPTH ?
				`TBSP_FIFO_DEPTH : n);
		end
	endtask

	task frame(input logic m, p, s, input int nf, ws);
		int c, ch, f;
		tbsp_byte_t b, x;
		logic [8:0] y;
		begin
			@(negedge clk);
			e1_mode = m;
			nibble_position_select = p;
			signaling_source_select = s;
			for (c = 1; c <= 30 && ws; c++)
				sig_write(c[4:0], 4'($urandom));
			fill(nf);
			for (c = 0; c < 32; c++)
			begin
				M.din_b[c] = 8'($urandom);
				M.ctl_b[c] = 8'($urandom);
			end
			chq.delete();
			sgq.delete();
			f = M.frames;
			run = 1;
			for (c = 0; c < 2000 && M.frames == f; c++)
				@(posedge clk);
			@(negedge clk);
			run = 0;
			check("frame_end", M.frames != f, 1'b1);
			check("tx_ch_count", chq.size(), m ? 30 : 24);
			check("tx_sig_count", sgq.size(), s ? 0 : 30);
			for (c = 0; c < 32; c++)
			begin
				ch = c < 16 ? c : c - 1;
				b = 8'hff;
				if (m ? c % 16 != 0 : c inside {[1:24]})
				begin
					if (q.size())
						b = q.pop_front();
					if (chq.size())
						check("tx_ch", chq.pop_front(),
							{m ? ch[4:0] : c[4:0], M.din_b[c]});
				end
				check("data_out", M.dout_b[c], b);
				b = c % 16 ? (p ? 8'hf0 : 8'h0f) : 8'h00;
				x = p ? {sig[ch], 4'h0} : {4'h0, sig[ch]};
				check("status_oe", M.oe_b[c], b);
				check("status", M.stat_b[c] & b, x & b);
				x = M.ctl_b[c];
				y = {ch[4:0], p ? x[7:4] : x[3:0]};
				if (!s && c % 16 != 0 && sgq.size())
					check("tx_sig", sgq.pop_front(), y);
			end
			$display("test done: e1 %0d pos %0d ign %0d", m, p, s);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end

	initial
	begin
		void'($urandom(32'hbc7b));
		do_reset();
		frame(1, 1, 0, 9, 1);
		frame(1, 0, 0, 3, 1);
		frame(0, 1, 1, 5, 1);
		// a second reset must clear the signaling table
		do_reset();
		frame(0, 0, 0, 8, 0);
		results();
	end
endmodule
